// >>> status_pkg.sv
package status_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int CMD_COUNT = 16;   // Commands in the list.
    localparam int CMD_IDX_W = 4;    // Width of a command index.
    localparam int WORD_W    = 16;   // Result word width.
    localparam int BYTE_W    = 8;    // Byte width.
    localparam int LEN_W     = 8;    // Reply length width.

    // ------------------------------------------------------------
    // Result codes
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_SUCCESS     = 16'h0000;
    localparam logic [15:0] CODE_DEST_NO_BUF = 16'h0100;
    localparam logic [15:0] CODE_APP_TIMEOUT = 16'h0500;
    localparam logic [7:0]  EXT_PRIMARY      = 8'hF0;
    localparam logic [7:0]  EXT_MIN          = 8'h01;
    localparam logic [7:0]  EXT_MAX          = 8'h1F;
    localparam logic [7:0]  EXT_ILLEGAL      = 8'h01;
    localparam logic [15:0] CODE_NO_CTS      = 16'hFFFF;
    localparam logic [15:0] CODE_TX_TIMEOUT  = 16'hFFFE;
    localparam logic [15:0] CODE_ACK_TIMEOUT = 16'hFFF6;
    localparam logic [15:0] CODE_RSP_TIMEOUT = 16'hFFF5;
    localparam logic [15:0] CODE_LEN_MISM    = 16'hFFF4;
    localparam logic [15:0] CODE_NAK_RX      = 16'hFFEC;
    localparam logic [15:0] CODE_NAK_TX      = 16'hFFEB;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Fault events seen during one command, one flag each.
    typedef struct packed {
        logic dest_no_buffer;
        logic app_timeout;
        logic no_cts;
        logic tx_timeout;
        logic ack_timeout;
        logic rsp_timeout;
        logic nak_received;
        logic nak_sent;
    } fault_t;

    // Remote reply contents.
    typedef struct packed {
        logic [7:0] primary_status_byte;
        logic [7:0] extended_status_byte;
        logic [7:0] reply_len;
    } reply_t;

    // Host read port for result words.
    typedef struct packed {
        logic       valid;
        logic [3:0] index;
    } rd_req_t;

endpackage

// >>> result_mem.sv
`timescale 1ns/100ps
// Small result-word memory with registered read data.
module result_mem #(
    parameter int DEPTH = 16,
    parameter int AW    = 4,
    parameter int DW    = 16
) (
    // Clock and reset.
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    // Write port.
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    // Read port.
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [DW-1:0] rd_data_out
);

    // Storage array, one word per command.
    logic [DW-1:0] mem [DEPTH];

    // Writes land at the clock edge.
    always_ff @(posedge clk_in)
    begin
        if (wr_en_in)
        begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    // Read data come from a register.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_data_out <= '0;
        end
        else
        begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule

// >>> command_status_code_encoder.sv
`timescale 1ns/100ps
module command_status_code_encoder #(
    // Size of the command list and width of its index.
    parameter int CMD_COUNT = status_pkg::CMD_COUNT,
    parameter int CMD_IDX_W = status_pkg::CMD_IDX_W
) (
    // Clock and reset.
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    // Configuration load from the host.
    input  wire logic                  config_done_in,
    output logic                       port_enable_out,
    // Command progress.
    input  wire logic                  cmd_start_in,
    input  wire logic [CMD_IDX_W-1:0]  cmd_index_in,
    input  wire logic [7:0]            cmd_req_len_in,
    input  wire status_pkg::fault_t    fault_in,
    input  wire logic                  reply_valid_in,
    input  wire status_pkg::reply_t    reply_in,
    input  wire logic                  cmd_done_in,
    // Host read of result words.
    input  wire status_pkg::rd_req_t   rd_req_in,
    output logic [15:0]                rd_data_out,
    output logic                       rd_valid_out,
    // Latest stored outcome.
    output logic                       result_write_out,
    output logic [CMD_IDX_W-1:0]       result_index_out,
    output logic [15:0]                result_word_out
);

    // ------------------------------------------------------------
    // Command tracking
    // ------------------------------------------------------------

    // Command states. Only one command is tracked at a time, so a start
    // that arrives while a command runs is ignored rather than queued.
    typedef enum logic [1:0] {IDLE_ST, ACTIVE_ST} cmd_state_t;

    // State of the running command, its first captured event, this cycle's event, config flag and read data.
    cmd_state_t            state;        // Command in progress or not.
    logic [CMD_IDX_W-1:0]  cur_index;    // Index of the running command.
    logic [7:0]            req_len;      // Byte count asked for.
    logic                  fault_seen;   // A fault already captured.
    logic [15:0]           held_code;    // First captured code.
    logic [15:0]           next_code;    // Code of this cycle's event.
    logic                  next_hit;     // This cycle has an event.
    logic                  configured;   // Host configuration loaded.
    logic [15:0]           mem_rd;       // Registered memory data.

    // ------------------------------------------------------------
    // Event classification
    // ------------------------------------------------------------

    // Map a fault set to its code; the first flag in priority wins.
    // Flags that fire together in one cycle still give one code, the
    // link-side faults ranking ahead of the application-level ones.
    // These codes are built here only, never taken from the station.
    function automatic logic [15:0] fault_code(status_pkg::fault_t f);
        logic [15:0] c;
        c = status_pkg::CODE_SUCCESS;
        if (f.no_cts)
            c = status_pkg::CODE_NO_CTS;
        else if (f.tx_timeout)
            c = status_pkg::CODE_TX_TIMEOUT;
        else if (f.ack_timeout)
            c = status_pkg::CODE_ACK_TIMEOUT;
        else if (f.nak_received)
            c = status_pkg::CODE_NAK_RX;
        else if (f.rsp_timeout)
            c = status_pkg::CODE_RSP_TIMEOUT;
        else if (f.nak_sent)
            c = status_pkg::CODE_NAK_TX;
        else if (f.dest_no_buffer)
            c = status_pkg::CODE_DEST_NO_BUF;
        else if (f.app_timeout)
            c = status_pkg::CODE_APP_TIMEOUT;
        return c;
    endfunction

    // Map a remote reply to its code, or success when clean.
    // An extended reply keeps its lower byte; any other remote code keeps
    // only its upper nibble. Neither form can land in the all-ones group
    // kept for local faults, so a station cannot fake one of those.
    // The length check applies only to a reply that reports no error.
    function automatic logic [15:0] reply_code(status_pkg::reply_t r,
                                               logic [7:0] want);
        logic [15:0] c;
        logic [7:0]  ext;
        c   = status_pkg::CODE_SUCCESS;
        ext = r.extended_status_byte;
        if (r.primary_status_byte == status_pkg::EXT_PRIMARY)
        begin
            // Out-of-range extended values count as illegal field.
            if (ext < status_pkg::EXT_MIN || ext > status_pkg::EXT_MAX)
                ext = status_pkg::EXT_ILLEGAL;
            c = {status_pkg::EXT_PRIMARY, ext};
        end
        else if (r.primary_status_byte != 8'h00)
        begin
            // Only the remote code's upper nibble passes through; the other 12 bits stay zero.
            c = {r.primary_status_byte[7:4], 4'h0, 8'h00};
        end
        else if (r.reply_len != want)
        begin
            c = status_pkg::CODE_LEN_MISM;
        end
        return c;
    endfunction

    // Classify this cycle's event.
    // A local fault outranks a reply seen in the same cycle, since the
    // fault means the reply cannot be trusted.
    always_comb
    begin
        next_code = fault_code(fault_in);
        next_hit  = (fault_in != '0);
        // A reply that reports success leaves next_hit low.
        if (!next_hit && reply_valid_in)
        begin
            next_code = reply_code(reply_in, req_len);
            next_hit  = (next_code != status_pkg::CODE_SUCCESS);
        end
    end

    // ------------------------------------------------------------
    // Configuration gate
    // ------------------------------------------------------------

    // Ports stay quiet until host configuration has been loaded.
    // The enable is a flop so that it never glitches; it rises on the
    // same edge that samples the load and stays high until reset.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            configured      <= 1'b0;
            port_enable_out <= 1'b0;
        end
        else
        begin
            if (config_done_in)
            begin
                configured <= 1'b1;
            end
            port_enable_out <= configured || config_done_in;
        end
    end

    // ------------------------------------------------------------
    // Command state and first-fault capture
    // ------------------------------------------------------------

    // Track the running command and latch only its first fault.
    // The held code and its flag are cleared at each start, so nothing
    // from an earlier command can leak into the word of a later one.
    // The index and length are latched at start and held to the end.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state      <= IDLE_ST;
            cur_index  <= '0;
            req_len    <= '0;
            fault_seen <= 1'b0;
            held_code  <= status_pkg::CODE_SUCCESS;
        end
        else
        begin
            case (state)
                IDLE_ST:
                begin
                    // A new command starts only once configured.
                    if (cmd_start_in && configured)
                    begin
                        state      <= ACTIVE_ST;
                        cur_index  <= cmd_index_in;
                        req_len    <= cmd_req_len_in;
                        fault_seen <= 1'b0;
                        held_code  <= status_pkg::CODE_SUCCESS;
                    end
                end
                ACTIVE_ST:
                begin
                    // Later faults are ignored once one is held.
                    if (next_hit && !fault_seen)
                    begin
                        fault_seen <= 1'b1;
                        held_code  <= next_code;
                    end
                    // A finished command returns to idle at once.
                    if (cmd_done_in)
                    begin
                        state <= IDLE_ST;
                    end
                end
                // Unused state codes fall back to idle.
                default:
                begin
                    state <= IDLE_ST;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Result write
    // ------------------------------------------------------------

    // On completion store the outcome, overwriting any older value.
    // The store pulse lasts one cycle; index and word then hold until
    // the next store, so the host side may watch them at leisure.
    // A command that saw no event writes zero over any old error.
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            result_write_out <= 1'b0;
            result_index_out <= '0;
            result_word_out  <= status_pkg::CODE_SUCCESS;
        end
        else
        begin
            // The store pulse drops unless a command ends now.
            result_write_out <= 1'b0;
            if (state == ACTIVE_ST && cmd_done_in)
            begin
                result_write_out <= 1'b1;
                result_index_out <= cur_index;
                // Same-cycle event counts if nothing held yet.
                if (fault_seen)
                    result_word_out <= held_code;
                else if (next_hit)
                    result_word_out <= next_code;
                else
                    result_word_out <= status_pkg::CODE_SUCCESS;
            end
        end
    end

    // Word storage, one entry per command.
    // Its write port takes the registered store outputs, so a word is
    // readable by a request made in the cycle after the store pulse.
    result_mem #(
        .DEPTH (CMD_COUNT),
        .AW    (CMD_IDX_W),
        .DW    (status_pkg::WORD_W)
    ) u_mem (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (result_write_out),
        .wr_addr_in  (result_index_out),
        .wr_data_in  (result_word_out),
        .rd_addr_in  (rd_req_in.index),
        .rd_data_out (mem_rd)
    );

    // ------------------------------------------------------------
    // Host read path
    // ------------------------------------------------------------

    // Memory data are one cycle late; stage them onto the outputs.
    // A read is answered two cycles after its request; back-to-back
    // requests are answered back to back. Read data hold between reads
    // so the host may sample them after the valid pulse.
    logic rd_pend; // Read issued last cycle.

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_pend      <= 1'b0;
            rd_valid_out <= 1'b0;
            rd_data_out  <= '0;
        end
        else
        begin
            // The valid pulse trails the request through two flops.
            rd_pend      <= rd_req_in.valid;
            rd_valid_out <= rd_pend;
            if (rd_pend)
            begin
                rd_data_out <= mem_rd;
            end
        end
    end

endmodule

// >>> status_encoder_assertions.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Port checker for the result-word encoder.
// ------------------------------------------------------------
module status_encoder_checker (
    // Clock and reset.
    input wire logic                clk_in,
    input wire logic                rst_b_in,
    // Watched ports.
    input wire logic                config_done_in,
    input wire logic                port_enable_out,
    input wire logic                cmd_done_in,
    input wire status_pkg::rd_req_t rd_req_in,
    input wire logic                rd_valid_out,
    input wire logic                result_write_out,
    input wire logic [15:0]         result_word_out
);
    // One clock domain, so clock and reset are given once here.
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_config_enables: assert property (config_done_in |=> port_enable_out)
        else $error("port not enabled after config load");
    a_enable_sticky: assert property (port_enable_out |=> port_enable_out)
        else $error("port enable dropped");
    a_write_needs_cfg: assert property (result_write_out |-> port_enable_out)
        else $error("result stored while unconfigured");
    a_write_after_done: assert property (result_write_out
        |-> $past(cmd_done_in) || $past(cmd_done_in, 2))
        else $error("result stored without command end");
    a_write_one_pulse: assert property (result_write_out |=> !result_write_out)
        else $error("store pulse longer than one cycle");
    a_word_changes_on_write: assert property ($changed(result_word_out)
        |-> result_write_out)
        else $error("result word moved without a store");
    a_ext_in_range: assert property (result_write_out
        && result_word_out[15:8] == 8'hF0
        |-> result_word_out[7:0] inside {[8'h01:8'h1F]})
        else $error("extended code out of range");
    a_remote_nibble: assert property (result_write_out
        && result_word_out[15:12] inside {[4'h1:4'hE]}
        |-> result_word_out[11:0] == 12'h000)
        else $error("remote code has low bits set");
    a_local_codes: assert property (result_write_out
        && result_word_out[15:12] == 4'h0
        |-> result_word_out inside {16'h0000, 16'h0100, 16'h0500})
        else $error("unexpected local code");
    a_read_answer: assert property (rd_req_in.valid |-> ##[2:3] rd_valid_out)
        else $error("read not answered in time");
endmodule

bind command_status_code_encoder status_encoder_checker u_chk (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .config_done_in(config_done_in),
    .port_enable_out(port_enable_out), .cmd_done_in(cmd_done_in),
    .rd_req_in(rd_req_in), .rd_valid_out(rd_valid_out),
    .result_write_out(result_write_out), .result_word_out(result_word_out));

// >>> slave_station_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// Remote station: reacts one cycle after a request, and may add
// a second fault in the cycle after that.
// ------------------------------------------------------------
module slave_station_model (
    // Clock.
    input  wire logic               clk_in,
    // Scenario control.
    input  wire logic               go_in,
    input  wire status_pkg::fault_t fault1_in,
    input  wire status_pkg::fault_t fault2_in,
    input  wire logic               reply_en_in,
    input  wire status_pkg::reply_t reply_in,
    // Toward the encoder.
    output status_pkg::fault_t      fault_out,
    output logic                    reply_valid_out,
    output status_pkg::reply_t      reply_out
);
    status_pkg::fault_t f2_q;       // Fault held for the second cycle.
    logic               go_q;       // Request seen one cycle ago.

    initial
    begin
        fault_out = '0;
        reply_valid_out = 1'b0;
        reply_out = '0;
        f2_q = '0;
        go_q = 1'b0;
    end

    // Events are one-cycle pulses; an idle reply bus toggles so that a
    // stale value can never pass for a fresh one.
    always @(posedge clk_in)
    begin
        go_q <= go_in;
        f2_q <= fault2_in;
        fault_out <= go_in ? fault1_in : (go_q ? f2_q : '0);
        reply_valid_out <= go_in & reply_en_in;
        reply_out <= (go_in & reply_en_in) ? reply_in : ~reply_out;
    end
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
module testbench;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic               clk_in = 1'b0;      // Design clock.
    logic               rst_b_in = 1'b0;    // Reset, held at start.
    logic               config_done_in = 1'b0;
    logic               cmd_start_in = 1'b0;
    logic [3:0]         cmd_index_in = '0;
    logic [7:0]         cmd_req_len_in = '0;
    logic               cmd_done_in = 1'b0;
    status_pkg::rd_req_t rd_req_in = '0;
    logic               go = 1'b0;          // Model request strobe.
    status_pkg::fault_t f1 = '0, f2 = '0;   // Model fault choices.
    logic               rep_en = 1'b0;      // Model sends a reply.
    status_pkg::reply_t rep = '0;           // Model reply contents.
    status_pkg::fault_t fault_in;
    logic               reply_valid_in, port_enable_out, rd_valid_out;
    status_pkg::reply_t reply_in;
    logic [15:0]        rd_data_out, result_word_out;
    logic               result_write_out;
    logic [3:0]         result_index_out;
    int                 fails = 0, cmp_count = 0, cycles = 0;

    always #5 clk_in = ~clk_in;

    command_status_code_encoder u_command_status_code_encoder (
        .clk_in(clk_in), .rst_b_in(rst_b_in),
        .config_done_in(config_done_in), .port_enable_out(port_enable_out),
        .cmd_start_in(cmd_start_in), .cmd_index_in(cmd_index_in),
        .cmd_req_len_in(cmd_req_len_in), .fault_in(fault_in),
        .reply_valid_in(reply_valid_in), .reply_in(reply_in),
        .cmd_done_in(cmd_done_in), .rd_req_in(rd_req_in),
        .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out),
        .result_write_out(result_write_out),
        .result_index_out(result_index_out),
        .result_word_out(result_word_out));

    slave_station_model u_slave_station_model (
        .clk_in(clk_in), .go_in(go), .fault1_in(f1), .fault2_in(f2),
        .reply_en_in(rep_en), .reply_in(rep), .fault_out(fault_in),
        .reply_valid_out(reply_valid_in), .reply_out(reply_in));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Compares one value and counts it.
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One command: start, station answer, end, then the stored word.
    task automatic run_cmd(input logic [3:0] idx, input logic [7:0] len,
        input status_pkg::fault_t a, b, input logic en,
        input status_pkg::reply_t r, input logic [15:0] exp);
        @(posedge clk_in) #1;
        {cmd_start_in, cmd_index_in, cmd_req_len_in} = {1'b1, idx, len};
        {go, f1, f2, rep_en, rep} = {1'b1, a, b, en, r};
        @(posedge clk_in) #1;
        {cmd_start_in, go} = 2'b00;
        @(posedge clk_in) #1;
        cmd_done_in = 1'b1;
        @(posedge clk_in) #1;
        cmd_done_in = 1'b0;
        for (int i = 0; i < 3 && result_write_out !== 1'b1; i++)
            @(posedge clk_in) #1;
        check("store", {15'h0, result_write_out}, 16'h1);
        check("index", {12'h0, result_index_out}, {12'h0, idx});
        check("word", result_word_out, exp);
    endtask

    // Host read of one result word.
    task automatic read_word(input logic [3:0] idx, input logic [15:0] exp);
        @(posedge clk_in) #1;
        rd_req_in = '{valid: 1'b1, index: idx};
        @(posedge clk_in) #1;
        rd_req_in = '0;
        for (int i = 0; i < 3 && rd_valid_out !== 1'b1; i++)
            @(posedge clk_in) #1;
        check("read valid", {15'h0, rd_valid_out}, 16'h1);
        check("read", rd_data_out, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // A command before configuration is ignored; config opens the port.
    task automatic t_config();
        check("enable idle", {15'h0, port_enable_out}, 16'h0);
        @(posedge clk_in) #1;
        cmd_start_in = 1'b1;
        @(posedge clk_in) #1;
        {cmd_start_in, cmd_done_in} = 2'b01;
        @(posedge clk_in) #1;
        cmd_done_in = 1'b0;
        repeat (3)
        begin
            check("no store", {15'h0, result_write_out}, 16'h0);
            @(posedge clk_in) #1;
        end
        config_done_in = 1'b1;
        @(posedge clk_in) #1;
        config_done_in = 1'b0;
        @(posedge clk_in) #1;
        check("enable", {15'h0, port_enable_out}, 16'h1);
    endtask

    // Each local fault alone, one command index per fault.
    task automatic t_faults();
        logic [15:0] exp [8] = '{status_pkg::CODE_DEST_NO_BUF,
            status_pkg::CODE_APP_TIMEOUT, status_pkg::CODE_NO_CTS,
            status_pkg::CODE_TX_TIMEOUT, status_pkg::CODE_ACK_TIMEOUT,
            status_pkg::CODE_RSP_TIMEOUT, status_pkg::CODE_NAK_RX,
            status_pkg::CODE_NAK_TX};
        for (int i = 0; i < 8; i++)
            run_cmd(4'(i), 8'h04, 8'h80 >> i, '0, 1'b0, '0, exp[i]);
        read_word(4'h0, status_pkg::CODE_DEST_NO_BUF);
    endtask

    // Remote replies: plain codes, extended codes, length checks.
    task automatic t_remote();
        logic [39:0] tab [8] = '{{24'h100004, 16'h1000},
            {24'h9A0004, 16'h9000}, {24'hF00504, 16'hF005},
            {24'hF01F04, 16'hF01F}, {24'hF02004, 16'hF001},
            {24'hF00004, 16'hF001}, {24'h000005, 16'hFFF4},
            {24'h000004, 16'h0000}};
        for (int i = 0; i < 8; i++)
            run_cmd(4'(8 + i), 8'h04, '0, '0, 1'b1, tab[i][39:16], tab[i][15:0]);
    endtask

    // First fault wins; a later success overwrites the word.
    task automatic t_first_then_clear();
        run_cmd(4'h3, 8'h02, 8'h01, 8'h20, 1'b0, '0, 16'hFFEB);
        read_word(4'h3, 16'hFFEB);
        run_cmd(4'h3, 8'h02, '0, '0, 1'b1, 24'h000002, 16'h0000);
        read_word(4'h3, 16'h0000);
        // An event in the cycle of the command's end still counts.
        run_cmd(4'h5, 8'h02, '0, 8'h10, 1'b0, '0, 16'hFFFE);
        read_word(4'h5, 16'hFFFE);
    endtask

    // ------------------------------------------------------------
    // Main sequence and timeout
    // ------------------------------------------------------------
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles >= 2000)
        begin
            fails++;
            stop_test();
        end
    end

    initial
    begin
        repeat (5) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        t_config();
        t_faults();
        t_remote();
        t_first_then_clear();
        stop_test();
    end
endmodule
